// >>> src/dis_defs.vh
// Constants for the DDR3 initialization and mode register sequencer (device side)
`ifndef DIS_DEFS_VH
`define DIS_DEFS_VH
`define DIS_CLK_PERIOD_PS 5000
`define DIS_DLL_LOCK_CYCLES 512
`define DIS_CAL_TIME_NS 640
`define DIS_MODE_UPDATE_NS 60
`define DIS_CMD_W 3
`define DIS_CMD_NOP 3'h0
`define DIS_CMD_DES 3'h1
`define DIS_CMD_MRS 3'h2
`define DIS_CMD_ZQCL 3'h3
`define DIS_CMD_OTHER 3'h4
`define DIS_MR_W 18
`define DIS_MR_DLL_RST_BIT 8
`define DIS_BA_MR0 3'h0
`define DIS_BA_MR1 3'h1
`define DIS_BA_MR2 3'h2
`define DIS_BA_MR3 3'h3
`define DIS_ST_RESET 3'h0
`define DIS_ST_WAIT_CKE 3'h1
`define DIS_ST_MR2 3'h2
`define DIS_ST_MR3 3'h3
`define DIS_ST_MR1 3'h4
`define DIS_ST_MR0 3'h5
`define DIS_ST_ZQ 3'h6
`define DIS_ST_DONE 3'h7
`endif

// >>> src/dis_init_seq.v
// DDR3 device-side initialization and mode register set sequencer
`include "dis_defs.vh"
module dis_init_seq #(
  parameter CLK_PERIOD_PS = `DIS_CLK_PERIOD_PS,
  parameter DLL_LOCK_CYCLES = `DIS_DLL_LOCK_CYCLES,
  parameter CAL_TIME_NS = `DIS_CAL_TIME_NS,
  parameter MODE_UPDATE_NS = `DIS_MODE_UPDATE_NS
) (
  input wire clk_in,
  input wire resetn_in,
  input wire cke_in,
  input wire odt_in,
  input wire [`DIS_CMD_W-1:0] cmd_in,
  input wire [2:0] ba_in,
  input wire [`DIS_MR_W-1:0] addr_in,
  output reg [`DIS_MR_W-1:0] mr0_out,
  output reg [`DIS_MR_W-1:0] mr1_out,
  output reg [`DIS_MR_W-1:0] mr2_out,
  output reg [`DIS_MR_W-1:0] mr3_out,
  output reg odt_enable_out,
  output reg dll_locked_out,
  output reg cal_done_out,
  output reg ready_out,
  output reg mode_updating_out,
  output reg seq_error_out,
  output wire [2:0] state_out
);
  // Least times round up to whole cycles
  localparam integer CAL_CYC_I = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam integer MOD_CYC_I = (MODE_UPDATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam integer DLL_CYC_I = DLL_LOCK_CYCLES;
  // Counters are 16 bits; longer waits need a wider counter
  localparam [15:0] CAL_CYC = CAL_CYC_I[15:0];
  localparam [15:0] MOD_CYC = MOD_CYC_I[15:0];
  localparam [15:0] DLL_CYC = DLL_CYC_I[15:0];

  localparam [2:0] ST_RESET = `DIS_ST_RESET;
  localparam [2:0] ST_WAIT_CKE = `DIS_ST_WAIT_CKE;
  localparam [2:0] ST_MR2 = `DIS_ST_MR2;
  localparam [2:0] ST_MR3 = `DIS_ST_MR3;
  localparam [2:0] ST_MR1 = `DIS_ST_MR1;
  localparam [2:0] ST_MR0 = `DIS_ST_MR0;
  localparam [2:0] ST_ZQ = `DIS_ST_ZQ;
  localparam [2:0] ST_DONE = `DIS_ST_DONE;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg cke_q;
  reg mod_run_q;
  wire is_mrs;
  wire is_zq;
  wire is_idle_cmd;
  wire is_other_cmd;
  wire mr0_load;
  wire dll_rst_req;
  wire cal_start;
  wire bad_bank;
  wire in_load_states;
  wire order_err;
  wire update_violation;
  wire [`DIS_MR_W-1:0] dll_rst_mask;
  wire dll_done;
  wire cal_done;
  wire mod_done;
  wire mod_busy;
  wire odt_allowed;
  wire ready_d;

  assign state_out = state_q;
  assign is_mrs = cke_in && (cmd_in == `DIS_CMD_MRS);
  assign is_zq = cke_in && (cmd_in == `DIS_CMD_ZQCL);
  // With CKE high, NOP, deselect and MRS are the only commands allowed while an update runs
  assign is_idle_cmd = (cmd_in == `DIS_CMD_NOP) || (cmd_in == `DIS_CMD_DES);
  assign is_other_cmd = cke_in && !is_idle_cmd && (cmd_in != `DIS_CMD_MRS);
  assign mr0_load = is_mrs && (ba_in == `DIS_BA_MR0);
  assign dll_rst_req = mr0_load && addr_in[`DIS_MR_DLL_RST_BIT];
  assign cal_start = is_zq && (state_q == ST_ZQ);
  assign bad_bank = is_mrs && (ba_in > `DIS_BA_MR3);
  assign in_load_states = (state_q >= ST_MR2) && (state_q <= ST_MR0);
  assign order_err = is_mrs && in_load_states && (state_d == state_q);
  assign update_violation = mod_busy && is_other_cmd;
  assign dll_rst_mask = {{(`DIS_MR_W-1){1'b0}}, 1'b1} << `DIS_MR_DLL_RST_BIT;
  assign mod_busy = mod_run_q && !mod_done;
  // Termination waits for registered CKE and a quiet mode update
  assign odt_allowed = cke_q && !mod_busy && !is_mrs;
  assign ready_d = dll_done && cal_done && (state_q == ST_DONE);

  // One counter per wait keeps DLL lock and calibration overlapping
  dis_wait_counter #(.W(16)) u_dll (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(1'b0),
    .start_in(dll_rst_req),
    .load_in(DLL_CYC),
    .done_out(dll_done)
  );
  dis_wait_counter #(.W(16)) u_cal (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(1'b0),
    .start_in(cal_start),
    .load_in(CAL_CYC),
    .done_out(cal_done)
  );
  // A reload restarts the update wait from its full length
  dis_wait_counter #(.W(16)) u_mod (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(1'b0),
    .start_in(is_mrs),
    .load_in(MOD_CYC),
    .done_out(mod_done)
  );

  // Reset-exit wait is left to the controller; not checked here
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = ST_WAIT_CKE;
      ST_WAIT_CKE: if (cke_in) state_d = ST_MR2;
      ST_MR2: if (is_mrs && ba_in == `DIS_BA_MR2) state_d = ST_MR3;
      ST_MR3: if (is_mrs && ba_in == `DIS_BA_MR3) state_d = ST_MR1;
      ST_MR1: if (is_mrs && ba_in == `DIS_BA_MR1) state_d = ST_MR0;
      ST_MR0: if (is_mrs && ba_in == `DIS_BA_MR0) state_d = ST_ZQ;
      ST_ZQ: if (is_zq) state_d = ST_DONE;
      ST_DONE: state_d = ST_DONE;
      default: state_d = ST_RESET;
    endcase
  end

  // Sequencer state, CKE history and update tracking
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_RESET;
      cke_q <= 1'b0;
      mod_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_q <= cke_q | cke_in;
      if (is_mrs) begin
        mod_run_q <= 1'b1;
      end
    end
  end

  // Whole value replaces the register, with the MR0 DLL reset bit stored as 0; the array is never touched here
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mr0_out <= {`DIS_MR_W{1'b0}};
      mr1_out <= {`DIS_MR_W{1'b0}};
      mr2_out <= {`DIS_MR_W{1'b0}};
      mr3_out <= {`DIS_MR_W{1'b0}};
    end else if (is_mrs) begin
      case (ba_in)
        `DIS_BA_MR0: mr0_out <= addr_in & ~dll_rst_mask;
        `DIS_BA_MR1: mr1_out <= addr_in;
        `DIS_BA_MR2: mr2_out <= addr_in;
        `DIS_BA_MR3: mr3_out <= addr_in;
        default: ;
      endcase
    end
  end

  // Termination and mode update indication
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      odt_enable_out <= 1'b0;
      mode_updating_out <= 1'b0;
    end else begin
      odt_enable_out <= odt_allowed && odt_in;
      mode_updating_out <= is_mrs || mod_busy;
    end
  end

  // Sticky lock and calibration flags; ready is re-registered every cycle and needs both waits and a finished sequence
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dll_locked_out <= 1'b0;
      cal_done_out <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      if (dll_done) begin
        dll_locked_out <= 1'b1;
      end
      if (cal_done) begin
        cal_done_out <= 1'b1;
      end
      ready_out <= ready_d;
    end
  end

  // Sticky error: bad bank, command inside an update, or load out of order
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seq_error_out <= 1'b0;
    end else if (bad_bank || update_violation || order_err) begin
      seq_error_out <= 1'b1;
    end
  end
endmodule // dis_init_seq

// >>> src/dis_wait_counter.v
// Down counter that reports when a programmed wait has elapsed
module dis_wait_counter #(
  parameter W = 16
) (
  input wire clk_in,
  input wire resetn_in,
  input wire clear_in,
  input wire start_in,
  input wire [W-1:0] load_in,
  output wire done_out
);
  reg [W-1:0] cnt_q;
  reg run_q;
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (clear_in) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (start_in) begin
      cnt_q <= load_in;
      run_q <= 1'b1;
    end else if (run_q && cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done_out = run_q && (cnt_q == {W{1'b0}});
endmodule // dis_wait_counter

// >>> tb/dis_ctrl_model.sv
// Controller model driving the device command pins
`include "dis_defs.vh"
module dis_ctrl_model (
  input wire clk_in,
  output logic cke_out,
  output logic odt_out,
  output logic [2:0] cmd_out,
  output logic [2:0] ba_out,
  output logic [17:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke_out = 1'b0;
    odt_out = 1'b0;
    cmd_out = `DIS_CMD_NOP;
    ba_out = 3'h0;
    addr_out = 18'h0;
  end
  task automatic pins(input logic k, input logic o);
    @(posedge clk_in);
    cke_out <= k;
    odt_out <= o;
  endtask
  // Address toggles when idle so a stale value never looks held
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_in);
      cmd_out <= `DIS_CMD_NOP;
      addr_out <= ~addr_out;
    end
  endtask
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [17:0] a);
    @(posedge clk_in);
    cmd_out <= c;
    ba_out <= b;
    addr_out <= a;
    idle(16);
  endtask
  // Second command lands inside the update wait on purpose
  task automatic pair(input logic [2:0] c, input logic [2:0] b, input logic [17:0] a, input logic [2:0] c2);
    @(posedge clk_in);
    cmd_out <= c;
    ba_out <= b;
    addr_out <= a;
    @(posedge clk_in);
    cmd_out <= c2;
    idle(16);
  endtask
endmodule // dis_ctrl_model

// >>> tb/dis_props.sv
// Concurrent checks on the init sequencer ports
`include "dis_defs.vh"
module dis_props (
  input wire clk_in,
  input wire resetn_in,
  input wire cke_in,
  input wire [2:0] cmd_in,
  input wire [2:0] ba_in,
  input wire [17:0] addr_in,
  input wire [17:0] mr0_out,
  input wire [17:0] mr2_out,
  input wire odt_enable_out,
  input wire dll_locked_out,
  input wire cal_done_out,
  input wire ready_out,
  input wire mode_updating_out,
  input wire [2:0] state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire mrs = cke_in && cmd_in == `DIS_CMD_MRS;
  // Saturates so a stale lock never wraps back into range
  reg [9:0] lock_q;
  always @(posedge clk_in or negedge resetn_in)
    if (!resetn_in) lock_q <= 10'h0;
    else if (mrs && ba_in == `DIS_BA_MR0 && addr_in[`DIS_MR_DLL_RST_BIT]) lock_q <= 10'h1;
    else if (lock_q != 10'h0 && lock_q != 10'h3FF) lock_q <= lock_q + 10'h1;
  a_odt_held_off: assert property (state_out < 3'h2 |-> !odt_enable_out) else $error("odt on early");
  a_dll_bit_clear: assert property (mr0_out[`DIS_MR_DLL_RST_BIT] == 1'b0) else $error("dll bit stored");
  a_mode_hold: assert property (!$past(mrs) |-> $stable(mr2_out)) else $error("mode reg changed");
  a_lock_not_early: assert property ($rose(dll_locked_out) |-> lock_q >= 10'h200) else $error("lock early");
  a_lock_in_time: assert property (lock_q == 10'h208 |-> dll_locked_out) else $error("lock late");
  a_ready_cause: assert property (ready_out |-> dll_locked_out && cal_done_out) else $error("ready early");
  a_update_window: assert property (mrs |=> mode_updating_out [*8]) else $error("update short");
  a_update_cause: assert property ($rose(mode_updating_out) |-> $past(mrs)) else $error("update stray");
  cover property ($rose(ready_out));
  cover property ($rose(odt_enable_out));
  cover property (mrs && ba_in == `DIS_BA_MR0);
endmodule // dis_props
bind dis_init_seq dis_props u_props (.clk_in, .resetn_in, .cke_in, .cmd_in, .ba_in, .addr_in, .mr0_out,
  .mr2_out, .odt_enable_out, .dll_locked_out, .cal_done_out, .ready_out, .mode_updating_out, .state_out);

// >>> tb/test_sdram_init_mode_set_sequencer.sv
// Self-checking bench for the init sequencer
`include "dis_defs.vh"
module test_sdram_init_mode_set_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  wire cke, odt, odt_en, locked, cal, rdy, upd, err;
  wire [2:0] cmd, ba, st;
  wire [17:0] addr, mr0, mr1, mr2, mr3;
  int num_errors = 0;
  int checks = 0;
  always #2.5 clk_in = ~clk_in;
  dis_ctrl_model u_ctl (.clk_in, .cke_out(cke), .odt_out(odt), .cmd_out(cmd), .ba_out(ba), .addr_out(addr));
  dis_init_seq dut_u (.clk_in, .resetn_in, .cke_in(cke), .odt_in(odt), .cmd_in(cmd), .ba_in(ba), .addr_in(addr),
    .mr0_out(mr0), .mr1_out(mr1), .mr2_out(mr2), .mr3_out(mr3), .odt_enable_out(odt_en), .dll_locked_out(locked),
    .cal_done_out(cal), .ready_out(rdy), .mode_updating_out(upd), .seq_error_out(err), .state_out(st));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset;
    u_ctl.pins(1'b0, 1'b0);
    @(posedge clk_in) resetn_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    u_ctl.idle(4);
  endtask
  task automatic t_init;
    u_ctl.pins(1'b0, 1'b1);
    u_ctl.idle(4);
    #1;
    check(odt_en, 1'b0);
    u_ctl.pins(1'b1, 1'b0);
    u_ctl.idle(2);
    u_ctl.issue(`DIS_CMD_MRS, `DIS_BA_MR2, 18'h00A18);
    u_ctl.issue(`DIS_CMD_MRS, `DIS_BA_MR3, 18'h00004);
    u_ctl.issue(`DIS_CMD_MRS, `DIS_BA_MR1, 18'h00044);
    u_ctl.issue(`DIS_CMD_MRS, `DIS_BA_MR0, 18'h01520);
    u_ctl.issue(`DIS_CMD_ZQCL, 3'h0, 18'h00400);
    #1;
    check(rdy, 1'b0);
    for (int i = 0; i < 1000 && rdy !== 1'b1; i++) @(posedge clk_in);
    #1;
    check(rdy, 1'b1);
    check(locked, 1'b1);
    check(cal, 1'b1);
    check(mr0, 18'h01420);
    check(mr1, 18'h00044);
    check(mr2, 18'h00A18);
    check(mr3, 18'h00004);
    check(err, 1'b0);
    u_ctl.pins(1'b1, 1'b1);
    u_ctl.idle(2);
    #1;
    check(odt_en, 1'b1);
    $display("t_init done");
  endtask
  // Mid-run reset, then a load out of order
  task automatic t_order;
    do_reset;
    #1;
    check(mr2, 18'h0);
    u_ctl.pins(1'b1, 1'b0);
    u_ctl.idle(2);
    u_ctl.issue(`DIS_CMD_MRS, `DIS_BA_MR3, 18'h00004);
    #1;
    check(err, 1'b1);
    check(st, `DIS_ST_MR2);
    check(upd, 1'b0);
    u_ctl.issue(`DIS_CMD_MRS, 3'h5, 18'h3FFFF);
    #1;
    check(mr0, 18'h0);
    check(mr3, 18'h00004);
    check(st, `DIS_ST_MR2);
    $display("t_order done");
  endtask
  // Only NOP, deselect or MRS may follow a load inside the update wait; other commands set the error
  task automatic t_busy;
    do_reset;
    u_ctl.pins(1'b1, 1'b0);
    u_ctl.idle(2);
    u_ctl.pair(`DIS_CMD_MRS, `DIS_BA_MR2, 18'h00A18, `DIS_CMD_DES);
    #1;
    check(err, 1'b0);
    check(st, `DIS_ST_MR3);
    u_ctl.pair(`DIS_CMD_MRS, `DIS_BA_MR3, 18'h00004, `DIS_CMD_OTHER);
    #1;
    check(err, 1'b1);
    check(st, `DIS_ST_MR1);
    $display("t_busy done");
  endtask
  initial begin
    do_reset;
    t_init;
    t_order;
    t_busy;
    report_and_stop;
  end
endmodule // test_sdram_init_mode_set_sequencer
